/* File: hdl/aeq_pkg.sv */
// Package with register map, field layout, reset values and states of the adaptive equalizer control
// Overview of operation
// - Upper filter limit held in bits 7:4
// - Lower filter limit held in bits 3:0
// - Limits clamp filter during adaption and control
// - Error select bits choose counted error classes
// - Errors accumulate over half relock period
// - Count above threshold raises equalizer setting
// - One-step waits full period, checks lock
// - Two-step: half wait, half count, skip
// - Order bit picks largest delay or centre
// - Nesting bit picks inner and outer loop
// - Enable bit adds filter adaption to search
// - Eight-bit threshold sets re-adaption error count
package aeq_pkg;
	// Register offsets
	localparam logic [7:0] OFS_FILTER_LIMITS = 8'h41;
	localparam logic [7:0] OFS_EQ_CONTROL    = 8'h42;
	localparam logic [7:0] OFS_ERR_THRESHOLD = 8'h43;
	// Reset values
	localparam logic [7:0] RST_FILTER_LIMITS = 8'hA9;
	localparam logic [7:0] RST_EQ_CONTROL    = 8'h71;
	localparam logic [7:0] RST_ERR_THRESHOLD = 8'h01;
	// Writable bits of the control register, bit 7 reserved
	localparam logic [7:0] CTL_WR_MASK       = 8'h7F;
	// Field positions
	localparam int UPPER_HI  = 7;
	localparam int UPPER_LO  = 4;
	localparam int LOWER_HI  = 3;
	localparam int LOWER_LO  = 0;
	localparam int ERRSEL_HI = 6;
	localparam int ERRSEL_LO = 4;
	localparam int ORDER_BIT = 3;
	localparam int TWOSTEP_BIT = 2;
	localparam int NEST_BIT  = 1;
	localparam int FADAPT_BIT = 0;
	// Error select bit positions inside the three-bit field
	localparam int ESEL_CLK  = 2;
	localparam int ESEL_SEQ  = 1;
	localparam int ESEL_PAR  = 0;
	// Filter centre point and largest allowed value
	localparam logic [3:0] FILTER_MID = 4'h7;
	localparam logic [3:0] FILTER_TOP = 4'hE;
	// Adaption state machine
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_SETTLE  = 3'b001,
		ST_MEASURE = 3'b010,
		ST_STEP    = 3'b011,
		ST_LOCKED  = 3'b100
	} aeq_state_t;
endpackage : aeq_pkg

/* File: hdl/aeq_control.sv */
// Adaptive equalizer control: registers, search state machine and error accumulation
`timescale 1ns/1ps
module aeq_control #(
	parameter int EQ_W     = 4,   // Width of the equalizer setting
	parameter int EQ_MAX   = 15,  // Largest equalizer setting
	parameter int RELOCK_W = 16   // Width of the relock period input
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Register port
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	output logic      [7:0]          reg_rdata,
	// Configuration and control
	input  wire logic [RELOCK_W-1:0] relock_period,
	input  wire logic                adapt_start,
	// Receive path status
	input  wire logic                lock_pin,
	input  wire logic                clk_bit_err,
	input  wire logic                seq_err,
	input  wire logic                parity_err,
	// Settings towards the analog path
	output logic      [EQ_W-1:0]     eq_setting,
	output logic      [3:0]          sampling_filter,
	output logic                     adapt_busy,
	output logic                     adapt_locked
);
	// Register storage
	logic [7:0]            limits_r;     // Filter limits
	logic [7:0]            ctrl_r;       // Control fields
	logic [7:0]            thresh_r;     // Error threshold
	// Search state
	aeq_pkg::aeq_state_t   state_r;      // Adaption state
	aeq_pkg::aeq_state_t   state_nxt;    // Next adaption state
	logic [RELOCK_W-1:0]   timer_r;      // Half-period timer
	logic [8:0]            err_cnt_r;    // Accumulated errors
	logic [EQ_W-1:0]       eq_r;         // Equalizer setting under trial
	logic [3:0]            sf_r;         // Filter setting under trial
	logic [3:0]            sf_steps_r;   // Filter steps taken in one sweep
	logic [3:0]            sf_out_r;     // Clamped filter output
	logic                  lock_meta_r;  // Lock synchroniser first stage
	logic                  lock_s_r;     // Lock synchroniser second stage
	// Derived terms
	logic [3:0]            upper;        // Upper filter limit
	logic [3:0]            lower;        // Lower filter limit
	logic [2:0]            err_sel;      // Enabled error classes
	logic                  err_hit;      // Any enabled error this cycle
	logic [RELOCK_W-1:0]   half_m1;      // Half period minus one
	logic                  tmr_end;      // Timer at end of half period
	logic                  over_thr;     // Count above threshold
	logic [9:0]            err_total;    // Window count including this cycle's error
	logic [3:0]            sf_start;     // First filter setting
	logic [3:0]            sf_adv;       // Filter setting after one step
	logic                  sf_wrap;      // Filter sweep finished
	logic                  eq_wrap;      // Equalizer at top

	// Field extraction
	// upper limit field
	assign upper   = limits_r[aeq_pkg::UPPER_HI:aeq_pkg::UPPER_LO];
	assign lower   = limits_r[aeq_pkg::LOWER_HI:aeq_pkg::LOWER_LO];
	assign err_sel = ctrl_r[aeq_pkg::ERRSEL_HI:aeq_pkg::ERRSEL_LO];
	assign err_hit = (err_sel[aeq_pkg::ESEL_CLK] & clk_bit_err) | (err_sel[aeq_pkg::ESEL_SEQ] & seq_err)
		| (err_sel[aeq_pkg::ESEL_PAR] & parity_err);
	// half of the configured relock period, never below one cycle
	assign half_m1 = (relock_period[RELOCK_W-1:1] == '0) ? '0 : {1'b0, relock_period[RELOCK_W-1:1]} - RELOCK_W'(1);
	assign tmr_end = (timer_r >= half_m1);
	// threshold compare, the window's last cycle counted too, since the clear drops it
	assign err_total = {1'b0, err_cnt_r} + {9'h000, err_hit};
	assign over_thr  = (err_total > {2'b00, thresh_r});
	// start at largest delay or at the centre point, within limits
	assign sf_start = ctrl_r[aeq_pkg::ORDER_BIT] ?
		((aeq_pkg::FILTER_MID > upper) ? upper : ((aeq_pkg::FILTER_MID < lower) ? lower : aeq_pkg::FILTER_MID)) :
		upper;
	// Walk downward and wrap to the upper limit
	assign sf_adv  = (sf_r <= lower) ? upper : sf_r - 4'h1;
	assign sf_wrap = (sf_steps_r >= (upper - lower));
	assign eq_wrap = (eq_r == EQ_W'(EQ_MAX));

	// Register writes, reserved bits kept at zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			limits_r <= aeq_pkg::RST_FILTER_LIMITS;
			ctrl_r   <= aeq_pkg::RST_EQ_CONTROL;
			thresh_r <= aeq_pkg::RST_ERR_THRESHOLD;
		end
		else if (reg_wr)
		begin
			// Address decode
			case (reg_addr)
				aeq_pkg::OFS_FILTER_LIMITS: limits_r <= reg_wdata;
				aeq_pkg::OFS_EQ_CONTROL:    ctrl_r   <= reg_wdata & aeq_pkg::CTL_WR_MASK;
				aeq_pkg::OFS_ERR_THRESHOLD: thresh_r <= reg_wdata;
				default:                    ;
			endcase
		end
	end

	// Register read mux, unmapped offsets read zero
	always_comb
	begin
		case (reg_addr)
			aeq_pkg::OFS_FILTER_LIMITS: reg_rdata = limits_r;
			aeq_pkg::OFS_EQ_CONTROL:    reg_rdata = ctrl_r;
			aeq_pkg::OFS_ERR_THRESHOLD: reg_rdata = thresh_r;
			default:                    reg_rdata = 8'h00;
		endcase
	end

	// Lock indication synchroniser
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lock_meta_r <= 1'b0;
			lock_s_r    <= 1'b0;
		end
		else
		begin
			lock_meta_r <= lock_pin;
			lock_s_r    <= lock_meta_r;
		end
	end

	// Next state of the search
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			// Wait for a start request
			aeq_pkg::ST_IDLE:
				if (adapt_start)
					state_nxt = aeq_pkg::ST_SETTLE;
			// First half of the relock period
			aeq_pkg::ST_SETTLE:
				if (tmr_end)
					state_nxt = aeq_pkg::ST_MEASURE;
			// Second half with error counting
			aeq_pkg::ST_MEASURE:
				// any enabled error in two-step mode moves on at once
				if (ctrl_r[aeq_pkg::TWOSTEP_BIT] && err_hit)
					state_nxt = aeq_pkg::ST_STEP;
				else if (tmr_end)
				begin
					// one-step judges on the instantaneous lock
					if (over_thr || (!ctrl_r[aeq_pkg::TWOSTEP_BIT] && !lock_s_r))
						state_nxt = aeq_pkg::ST_STEP;
					else
						state_nxt = aeq_pkg::ST_LOCKED;
				end
			// One cycle to pick the next setting
			aeq_pkg::ST_STEP:
				state_nxt = aeq_pkg::ST_SETTLE;
			// Monitor and re-adapt on too many errors
			aeq_pkg::ST_LOCKED:
				if (adapt_start)
					state_nxt = aeq_pkg::ST_SETTLE;
				// raise the setting when over threshold
				else if (tmr_end && over_thr)
					state_nxt = aeq_pkg::ST_STEP;
			default:
				state_nxt = aeq_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_r <= aeq_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Half-period timer, restarted on every state change
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			timer_r <= '0;
		else if ((state_nxt != state_r) || tmr_end)
			timer_r <= '0;
		else
			timer_r <= timer_r + 1'b1;
	end

	// error accumulation over each measuring or locked half period, saturating
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			err_cnt_r <= '0;
		else if ((state_nxt != state_r) || (tmr_end && (state_r == aeq_pkg::ST_LOCKED)))
			err_cnt_r <= '0;
		else if ((state_r == aeq_pkg::ST_MEASURE || state_r == aeq_pkg::ST_LOCKED) && err_hit && !(&err_cnt_r))
			err_cnt_r <= err_cnt_r + 9'h001;
	end

	// Trial settings: start point and loop stepping
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			eq_r       <= '0;
			sf_r       <= aeq_pkg::FILTER_MID;
			sf_steps_r <= '0;
		end
		else if (adapt_start && (state_r == aeq_pkg::ST_IDLE || state_r == aeq_pkg::ST_LOCKED))
		begin
			eq_r       <= '0;
			sf_r       <= sf_start;
			sf_steps_r <= '0;
		end
		else if (state_r == aeq_pkg::ST_STEP)
		begin
			// equalizer only when filter adaption is off
			if (!ctrl_r[aeq_pkg::FADAPT_BIT])
				eq_r <= eq_wrap ? '0 : eq_r + 1'b1;
			else if (!ctrl_r[aeq_pkg::NEST_BIT])
			begin
				eq_r <= eq_wrap ? '0 : eq_r + 1'b1;
				if (eq_wrap)
				begin
					sf_r       <= sf_adv;
					sf_steps_r <= sf_wrap ? 4'h0 : sf_steps_r + 4'h1;
				end
			end
			else
			begin
				sf_r       <= sf_adv;
				sf_steps_r <= sf_wrap ? 4'h0 : sf_steps_r + 4'h1;
				if (sf_wrap)
					eq_r <= eq_wrap ? '0 : eq_r + 1'b1;
			end
		end
	end

	// filter output clamped to the programmed limits
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			sf_out_r <= aeq_pkg::FILTER_MID;
		else if (sf_r > upper)
			sf_out_r <= upper;
		else if (sf_r < lower)
			sf_out_r <= lower;
		else
			sf_out_r <= sf_r;
	end

	// Outputs
	assign eq_setting      = eq_r;
	assign sampling_filter = sf_out_r;
	assign adapt_busy      = (state_r == aeq_pkg::ST_SETTLE) || (state_r == aeq_pkg::ST_MEASURE)
		|| (state_r == aeq_pkg::ST_STEP);
	assign adapt_locked    = (state_r == aeq_pkg::ST_LOCKED);

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	upper_field_a: assert property (reg_wr && reg_addr == aeq_pkg::OFS_FILTER_LIMITS
		|=> upper == $past(reg_wdata[aeq_pkg::UPPER_HI:aeq_pkg::UPPER_LO])) else $error("upper limit not stored");
	lower_field_a: assert property (reg_wr && reg_addr == aeq_pkg::OFS_FILTER_LIMITS
		|=> lower == $past(reg_wdata[aeq_pkg::LOWER_HI:aeq_pkg::LOWER_LO])) else $error("lower limit not stored");
	filter_clamp_a: assert property ((lower <= upper) && $stable(limits_r) [*2] |-> sampling_filter <= upper
		&& sampling_filter >= lower) else $error("filter outside limits");
	err_select_a: assert property (err_cnt_r > $past(err_cnt_r) |-> $past(err_hit))
		else $error("error counted while class disabled");
	half_window_a: assert property (state_r == aeq_pkg::ST_MEASURE && $past(state_r) == aeq_pkg::ST_SETTLE
		&& $stable(relock_period) |-> $past(timer_r) == $past(half_m1)) else $error("settle shorter than half period");
	raise_eq_a: assert property (state_r == aeq_pkg::ST_MEASURE && tmr_end && over_thr
		&& !(ctrl_r[aeq_pkg::TWOSTEP_BIT] && err_hit) |=> state_r == aeq_pkg::ST_STEP ##1 state_r == aeq_pkg::ST_SETTLE)
		else $error("threshold did not trigger step");
	one_step_a: assert property (state_r == aeq_pkg::ST_MEASURE && !ctrl_r[aeq_pkg::TWOSTEP_BIT]
		&& tmr_end && !over_thr |=> state_r == ($past(lock_s_r) ? aeq_pkg::ST_LOCKED : aeq_pkg::ST_STEP))
		else $error("one-step lock check wrong");
	two_step_a: assert property (state_r == aeq_pkg::ST_MEASURE && ctrl_r[aeq_pkg::TWOSTEP_BIT] && err_hit
		|=> state_r == aeq_pkg::ST_STEP) else $error("two-step error did not skip");
	start_order_a: assert property ((state_r == aeq_pkg::ST_IDLE || state_r == aeq_pkg::ST_LOCKED) && adapt_start
		&& !ctrl_r[aeq_pkg::ORDER_BIT] |=> sf_r == $past(upper)) else $error("search not started at upper limit");
	nest_outer_a: assert property (state_r == aeq_pkg::ST_STEP && ctrl_r[aeq_pkg::FADAPT_BIT]
		&& !ctrl_r[aeq_pkg::NEST_BIT] && !eq_wrap |=> $stable(sf_r)) else $error("filter moved while equalizer inner");
	filter_off_a: assert property (state_r == aeq_pkg::ST_STEP && !ctrl_r[aeq_pkg::FADAPT_BIT]
		|=> $stable(sf_r)) else $error("filter adapted while disabled");
	thresh_field_a: assert property (reg_wr && reg_addr == aeq_pkg::OFS_ERR_THRESHOLD
		|=> thresh_r == $past(reg_wdata)) else $error("threshold not stored");
endmodule : aeq_control

/* File: verif/aeq_ser_model.sv */
// Remote serializer model: lock indication and link error pulses
`timescale 1ns/1ps
module aeq_ser_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Behaviour chosen by the bench
	input  wire logic       link_good,
	input  wire logic [2:0] err_kind,
	// Link status towards the receiver
	output logic            lock_pin,
	output logic            clk_bit_err,
	output logic            seq_err,
	output logic            parity_err
);
	// Lock follows link quality, selected error classes pulse every cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lock_pin                           <= 1'b0;
			{clk_bit_err, seq_err, parity_err} <= 3'b000;
		end
		else
		begin
			lock_pin                           <= link_good;
			{clk_bit_err, seq_err, parity_err} <= err_kind;
		end
	end
endmodule : aeq_ser_model

/* File: verif/testbench.sv */
// Self-checking bench for the adaptive equalizer control block
`timescale 1ns/1ps
module testbench;
	// Stimulus, all driven 1 ns after the rising edge
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       adapt_start = 1'b0;
	logic       link_good = 1'b1;
	logic [2:0] err_kind = 3'b000;
	logic [15:0] relock = 16'h0008;
	// Observed outputs and link lines
	logic [7:0] reg_rdata;
	logic [3:0] eq_setting, sampling_filter;
	logic       adapt_busy, adapt_locked;
	logic       lock_pin, clk_bit_err, seq_err, parity_err;
	// Counters and scratch values
	int         fails = 0;
	int         tests_run = 0;
	int         cycles = 0;
	logic [3:0] up, lo;
	logic       ord;
	logic [7:0] d;

	// 250 MHz clock
	always #2 clk = ~clk;

	// Design under test, relock period of 8 cycles unless a test varies it
	aeq_control u_aeq_control (.clk, .arst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.relock_period(relock), .adapt_start, .lock_pin, .clk_bit_err, .seq_err, .parity_err,
		.eq_setting, .sampling_filter, .adapt_busy, .adapt_locked);
	// Far-side link model
	aeq_ser_model u_aeq_ser_model (.clk, .arst_n, .link_good, .err_kind, .lock_pin, .clk_bit_err,
		.seq_err, .parity_err);

	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// Compare one value
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Wait n edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// One-cycle register write, then an idle cycle so a following write never retoggles the strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
		cyc(1);
	endtask : wr

	// Combinational register read and compare
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		#1;
		chk(nm, reg_rdata, e);
		cyc(1);
	endtask : rd

	// One-cycle start pulse
	task automatic start();
		adapt_start = 1'b1;
		cyc(1);
		adapt_start = 1'b0;
	endtask : start

	// Bounded wait for the locked state
	task automatic wait_locked();
		for (int i = 0; i < 300 && adapt_locked !== 1'b1; i++)
			cyc(1);
		chk("lock reached", {7'h00, adapt_locked}, 8'h01);
	endtask : wait_locked

	// Starting filter value for a search
	function automatic logic [3:0] exp_start(input logic o, input logic [3:0] u, input logic [3:0] l);
		if (!o)
			return u;
		if (l > aeq_pkg::FILTER_MID)
			return l;
		return (u < aeq_pkg::FILTER_MID) ? u : aeq_pkg::FILTER_MID;
	endfunction : exp_start

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h626F));
		cyc(16);
		arst_n = 1'b1;
		cyc(1);
		rd("limits rst", 8'h41, 8'hA9);
		rd("control rst", 8'h42, 8'h71);
		rd("threshold rst", 8'h43, 8'h01);
		rd("unmapped", 8'h44, 8'h00);
		chk("eq rst", {4'h0, eq_setting}, 8'h00);
		chk("filter rst", {4'h0, sampling_filter}, 8'h09); // centre clamped up to reset lower limit
		$display("done: reset values");
		// Random register traffic within legal values
		for (int i = 0; i < 6; i++)
		begin
			lo = 4'($urandom % 15);
			up = 4'(lo + $urandom % (15 - lo));
			wr(8'h41, {up, lo});
			rd("limits", 8'h41, {up, lo});
			d = 8'($urandom);
			wr(8'h42, d);
			rd("control", 8'h42, d & 8'h7F);
			d = 8'($urandom % 255) + 8'h01;
			wr(8'h43, d);
			rd("threshold", 8'h43, d);
		end
		wr(8'h40, 8'h5A);
		rd("unmapped wr", 8'h40, 8'h00);
		rd("limits kept", 8'h41, {up, lo});
		$display("done: registers");
		// Start point, clamping and one-step full wait
		wr(8'h43, 8'hFF);
		for (int i = 0; i < 5; i++)
		begin
			lo = (i == 0) ? 4'h8 : 4'($urandom % 15);
			up = (i == 0) ? 4'h8 : 4'(lo + $urandom % (15 - lo));
			ord = (i == 0) ? 1'b1 : 1'($urandom);
			relock = (i == 0) ? 16'h0008 : 16'(4 + 2 * ($urandom % 4));
			wr(8'h41, {up, lo});
			wr(8'h42, {4'h0, ord, 3'b000});
			start();
			cyc(1);
			chk("start filter", {4'h0, sampling_filter}, {4'h0, exp_start(ord, up, lo)});
			cyc(int'(relock) - 2);
			chk("busy full wait", {7'h00, adapt_busy}, 8'h01);
			cyc(1);
			chk("locked", {7'h00, adapt_locked}, 8'h01);
			chk("eq kept", {4'h0, eq_setting}, 8'h00);
		end
		$display("done: search start");
		relock = 16'h0008;
		// Failed lock steps eq or filter as nesting asks
		wr(8'h41, 8'hA5);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h42, (i == 0) ? 8'h00 : ((i == 1) ? 8'h01 : 8'h03));
			link_good = 1'b0;
			start();
			cyc(2);
			for (int k = 0; k < 40 && eq_setting === 4'h0 && sampling_filter === 4'hA; k++)
				cyc(1);
			cyc(1);
			chk("step eq", {4'h0, eq_setting}, (i == 2) ? 8'h00 : 8'h01);
			chk("step filter", {4'h0, sampling_filter}, (i == 2) ? 8'h09 : 8'h0A);
			link_good = 1'b1;
			wait_locked();
		end
		$display("done: stepping");
		// Two-step check per error class, enabled and disabled
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h42, {1'b0, 3'(1 << (i % 3)), 4'h4});
			start();
			err_kind = (i < 3) ? 3'(1 << i) : 3'(1 << ((i + 1) % 3));
			cyc(8);
			chk("two step eq", {4'h0, eq_setting}, (i < 3) ? 8'h01 : 8'h00);
			chk("two step lock", {7'h00, adapt_locked}, (i < 3) ? 8'h00 : 8'h01);
			err_kind = 3'b000;
			wait_locked();
		end
		$display("done: error classes");
		// Threshold boundary while locked, four errors per window
		wr(8'h42, 8'h70);
		for (int i = 3; i < 5; i++)
		begin
			wr(8'h43, 8'(i));
			start();
			wait_locked();
			err_kind = 3'b100;
			cyc(14);
			chk("readapt", {7'h00, adapt_busy}, (i == 3) ? 8'h01 : 8'h00);
			err_kind = 3'b000;
			wait_locked();
		end
		$display("done: threshold");
		results();
	end
endmodule : testbench
